//--- rtl/sirq_slave.sv
// serialized interrupt slave: reports parallel requests on the shared line
// Contract
// R1 - one shared open-drain line: start, frames, stop
// R2 - quiet start: pull low one clock, release
// R3 - quiet start pulse only with request pending
// R4 - host extends start low to 4-8 clocks
// R5 - host drives high one clock, releases
// R6 - continuous mode: only host starts a cycle
// R7 - reset selects continuous mode
// R8 - count frames from start pulse rising edge
// R9 - each frame: sample, recovery, turnaround clocks
// R10 - sample clock: pull low if source active
// R11 - recovery after pulling low: drive high
// R12 - turnaround clock: line left undriven
// R13 - drive on clock edges from frame one
// R14 - frame n samples 3n-1 clocks after start
// R15 - fixed source frames, nothing else pulled low
// R16 - host ends cycle with 2-3 clock stop
// R17 - stop width two quiet, three continuous
// R18 - any idle clocks before next start
// R19 - start seen as low; idle high ignored
`timescale 1ns/100ps
module sirq_slave (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic serirq_i,
  input  wire logic irq_kbd_i,
  input  wire logic irq_smi_i,
  input  wire logic irq_ir_i,
  input  wire logic irq_uarta_i,
  input  wire logic irq_mouse_i,
  output logic      serirq_o,
  output logic      serirq_oe_o,
  output logic      quiet_mode_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  sirq_pkg::sirq_state_type                 state_reg;
  sirq_pkg::sirq_phase_type                 phase_reg;
  sirq_pkg::sirq_phase_type                 phase_next;
  logic [sirq_pkg::FRAME_W-1:0]             frame_reg;
  logic [sirq_pkg::FRAME_W-1:0]             frame_next;
  logic [sirq_pkg::CNT_W-1:0]               cnt_reg;
  logic [1:0]                               low_run_reg;
  logic                                     low_seen_reg;
  logic                                     quiet_reg;
  logic                                     serirq_o_reg;
  logic                                     serirq_oe_reg;
  logic [sirq_pkg::NUM_SRC-1:0]             irq_vec;
  logic                                     pending;
  logic                                     start_self;
  logic                                     start_end;
  logic                                     stop_seen;
  logic                                     frames_done;
  logic                                     stop_end;
  logic                                     go_frame;
  logic                                     drove_low;
  logic                                     drive_low_next;
  logic                                     drive_high_next;

  sirq_slot_if slot ();

  assign irq_vec = {irq_mouse_i, irq_uarta_i, irq_ir_i, irq_smi_i, irq_kbd_i};
  assign pending = |irq_vec;

  sirq_slot_map #(
    .NUM_SRC (sirq_pkg::NUM_SRC)
  ) u_slot_map (
    .irq_i (irq_vec),
    .slot  (slot)
  );

  // ************************************************************
  // cycle events
  // ************************************************************
  assign start_self  = (state_reg == sirq_pkg::ST_IDLE) && quiet_reg && pending && serirq_i; // R3
  assign start_end   = (state_reg == sirq_pkg::ST_START) && low_seen_reg && serirq_i; // R8
  // a low lasting two clocks inside the frames can only be the stop
  assign stop_seen   = (state_reg == sirq_pkg::ST_FRAME) && !serirq_i &&
                       (low_run_reg != sirq_pkg::LOW_RUN_ZERO);
  assign frames_done = (state_reg == sirq_pkg::ST_FRAME) && (phase_reg == sirq_pkg::PH_TURN) &&
                       (frame_reg == sirq_pkg::FRAME_LAST);
  assign stop_end    = (state_reg == sirq_pkg::ST_STOP) && serirq_i &&
                       (low_run_reg >= sirq_pkg::STOP_QUIET_LEN);
  assign go_frame    = start_end ||
                       ((state_reg == sirq_pkg::ST_FRAME) && !stop_seen && !frames_done);

  // ************************************************************
  // cycle state
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= sirq_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        sirq_pkg::ST_IDLE: begin
          if (start_self || !serirq_i) begin // R19 R6 R1
            state_reg <= sirq_pkg::ST_START;
          end
        end
        sirq_pkg::ST_START: begin
          if (start_end) begin // R4 R5
            state_reg <= sirq_pkg::ST_FRAME;
          end
        end
        sirq_pkg::ST_FRAME: begin
          if (stop_seen || frames_done) begin // R16
            state_reg <= sirq_pkg::ST_STOP;
          end
        end
        sirq_pkg::ST_STOP: begin
          if (stop_end) begin // R18
            state_reg <= sirq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= sirq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // start pulse must have been low before its rising edge counts
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      low_seen_reg <= 1'b0;
    end else if (state_reg != sirq_pkg::ST_START) begin
      low_seen_reg <= 1'b0;
    end else if (!serirq_i) begin
      low_seen_reg <= 1'b1;
    end
  end

  // saturating width of the current low run on the line
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      low_run_reg <= sirq_pkg::LOW_RUN_ZERO;
    end else if (serirq_i) begin
      low_run_reg <= sirq_pkg::LOW_RUN_ZERO;
    end else if (low_run_reg != sirq_pkg::STOP_CONT_LEN) begin
      low_run_reg <= low_run_reg + sirq_pkg::LOW_RUN_STEP;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      quiet_reg <= sirq_pkg::MODE_RESET_QUIET; // R7
    end else if (stop_end) begin
      quiet_reg <= (low_run_reg == sirq_pkg::STOP_QUIET_LEN); // R17
    end
  end

  // ************************************************************
  // frame sequencing
  // ************************************************************
  always_comb begin
    phase_next = phase_reg;
    frame_next = frame_reg;
    if (start_end) begin
      // clock 0 is the host high clock, clock 1 a turnaround
      phase_next = sirq_pkg::PH_TURN; // R8
      frame_next = sirq_pkg::FRAME_ZERO;
    end else if (state_reg == sirq_pkg::ST_FRAME) begin
      case (phase_reg)
        sirq_pkg::PH_SAMPLE: phase_next = sirq_pkg::PH_RECOV; // R9
        sirq_pkg::PH_RECOV:  phase_next = sirq_pkg::PH_TURN;
        sirq_pkg::PH_TURN: begin
          phase_next = sirq_pkg::PH_SAMPLE;
          frame_next = frame_reg + sirq_pkg::FRAME_STEP; // R14
        end
        default: phase_next = sirq_pkg::PH_SAMPLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      phase_reg <= sirq_pkg::PH_TURN;
      frame_reg <= sirq_pkg::FRAME_ZERO;
    end else begin
      phase_reg <= phase_next;
      frame_reg <= frame_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (start_end) begin
      cnt_reg <= sirq_pkg::CNT_AFTER_START;
    end else if (state_reg == sirq_pkg::ST_FRAME) begin
      cnt_reg <= cnt_reg + sirq_pkg::CNT_STEP;
    end
  end

  // ************************************************************
  // line driver
  // ************************************************************
  assign slot.frame      = frame_next;
  assign drove_low       = serirq_oe_reg && !serirq_o_reg;
  assign drive_low_next  = go_frame && (phase_next == sirq_pkg::PH_SAMPLE) && slot.req; // R10 R13
  assign drive_high_next = go_frame && (phase_next == sirq_pkg::PH_RECOV) && drove_low; // R11

  // turnaround and stop leave the enable low; idle raises it only for the quiet start pulse
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      serirq_oe_reg <= 1'b0;
      serirq_o_reg  <= 1'b1;
    end else begin
      serirq_oe_reg <= start_self || drive_low_next || drive_high_next; // R2 R12
      serirq_o_reg  <= drive_high_next;
    end
  end

  assign serirq_o     = serirq_o_reg;
  assign serirq_oe_o  = serirq_oe_reg;
  assign quiet_mode_o = quiet_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  chk_reset_mode_cont: assert property ($fell(rst_i) |-> !quiet_mode_o) // R7
    else $error("mode after reset is not continuous");
  chk_cont_no_start: assert property ((state_reg == sirq_pkg::ST_IDLE && !quiet_reg)
    |=> !(serirq_oe_o && !serirq_o)) // R6
    else $error("start pulled low in continuous mode");
  chk_start_one_clock: assert property ((state_reg == sirq_pkg::ST_START && drove_low)
    |=> !serirq_oe_o) // R2
    else $error("start pulse longer than one clock");
  chk_start_needs_req: assert property ((state_reg == sirq_pkg::ST_START && drove_low)
    |-> $past(pending) && $past(quiet_reg)) // R3
    else $error("start pulse without pending request");
  chk_recov_drives_high: assert property ((state_reg == sirq_pkg::ST_FRAME && drove_low
    && phase_reg == sirq_pkg::PH_SAMPLE && serirq_i == 1'b0 && low_run_reg == 2'h0)
    |=> serirq_oe_o && serirq_o) // R11
    else $error("recovery clock not driven high");
  chk_turn_released: assert property ((state_reg == sirq_pkg::ST_FRAME
    && phase_reg == sirq_pkg::PH_TURN) |-> !serirq_oe_o) // R12
    else $error("line driven in turnaround");
  chk_sample_position: assert property ((state_reg == sirq_pkg::ST_FRAME
    && phase_reg == sirq_pkg::PH_SAMPLE)
    |-> cnt_reg == 7'({1'b0, frame_reg} * sirq_pkg::CNT_PER_FRAME - sirq_pkg::CNT_STEP)) // R14
    else $error("sample clock at wrong offset");
  chk_low_only_slot: assert property ((state_reg == sirq_pkg::ST_FRAME && drove_low)
    |-> phase_reg == sirq_pkg::PH_SAMPLE && (frame_reg == sirq_pkg::FRAME_KBD
    || frame_reg == sirq_pkg::FRAME_SMI || frame_reg == sirq_pkg::FRAME_IR
    || frame_reg == sirq_pkg::FRAME_UARTA || frame_reg == sirq_pkg::FRAME_MOUSE)) // R10 R15
    else $error("line pulled low outside a mapped sample");
  chk_stop_sets_mode: assert property ((state_reg == sirq_pkg::ST_STOP && serirq_i
    && low_run_reg == sirq_pkg::STOP_QUIET_LEN) |=> quiet_mode_o ##1 quiet_mode_o) // R17
    else $error("two clock stop did not select quiet mode");
  chk_first_frame: assert property (start_end |=> ##1 phase_reg == sirq_pkg::PH_SAMPLE
    && frame_reg == 6'h01 && cnt_reg == sirq_pkg::CNT_FIRST_SAMPLE) // R8 R13
    else $error("first frame not two clocks after start");

  cov_quiet_start: cover property (start_self ##1 state_reg == sirq_pkg::ST_START);
  cov_mouse_report: cover property (drove_low && frame_reg == sirq_pkg::FRAME_MOUSE);
  cov_stop_quiet: cover property (stop_end && low_run_reg == sirq_pkg::STOP_QUIET_LEN);
  cov_stop_cont: cover property (stop_end && low_run_reg == sirq_pkg::STOP_CONT_LEN);
  cov_early_stop: cover property (stop_seen ##1 state_reg == sirq_pkg::ST_STOP);

endmodule // sirq_slave

//--- rtl/sirq_pkg.sv
// constants and types shared by the serialized interrupt slave
package sirq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_START = 2'h1,
    ST_FRAME = 2'h3,
    ST_STOP  = 2'h2
  } sirq_state_type;

  typedef enum logic [1:0] {
    PH_SAMPLE = 2'h0,
    PH_RECOV  = 2'h1,
    PH_TURN   = 2'h3
  } sirq_phase_type;

  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned FRAME_W = 6;
  localparam int unsigned CNT_W   = 7;

  // frame numbers of the reporting sources
  localparam logic [5:0] FRAME_KBD   = 6'h02;
  localparam logic [5:0] FRAME_SMI   = 6'h03;
  localparam logic [5:0] FRAME_IR    = 6'h04;
  localparam logic [5:0] FRAME_UARTA = 6'h05;
  localparam logic [5:0] FRAME_MOUSE = 6'h0d;
  localparam logic [5:0] FRAME_LAST  = 6'h20;
  localparam logic [5:0] FRAME_ZERO  = 6'h00;
  localparam logic [5:0] FRAME_STEP  = 6'h01;

  // source index i uses bits [i*6 +: 6]: kbd, smi, ir, uart a, mouse
  localparam logic [29:0] SLOT_TABLE = {FRAME_MOUSE, FRAME_UARTA, FRAME_IR, FRAME_SMI, FRAME_KBD};

  // stop frame low widths
  localparam logic [1:0] STOP_QUIET_LEN = 2'h2;
  localparam logic [1:0] STOP_CONT_LEN  = 2'h3;
  localparam logic [1:0] LOW_RUN_ZERO   = 2'h0;
  localparam logic [1:0] LOW_RUN_STEP   = 2'h1;

  // clock counter after the start pulse ends
  localparam logic [6:0] CNT_AFTER_START  = 7'h01;
  localparam logic [6:0] CNT_STEP         = 7'h01;
  localparam logic [6:0] CNT_FIRST_SAMPLE = 7'h02;
  localparam logic [6:0] CNT_PER_FRAME    = 7'h03;

  localparam logic MODE_RESET_QUIET = 1'b0;

endpackage

//--- rtl/sirq_slot_if.sv
// frame number to request lookup between controller and slot map
`timescale 1ns/100ps
interface sirq_slot_if;
  logic [5:0] frame;
  logic       req;

  modport ctrl (output frame, input req);
  modport map  (input frame, output req);
endinterface

//--- rtl/sirq_slot_map.sv
// maps interrupt sources onto their serial frames
`timescale 1ns/100ps
module sirq_slot_map #(
  parameter int unsigned NUM_SRC = sirq_pkg::NUM_SRC
) (
  input  wire logic [NUM_SRC-1:0] irq_i,
  sirq_slot_if.map                slot
);

  logic [NUM_SRC-1:0] hit;

  function automatic logic slot_match(input logic [5:0] frame, input int unsigned idx);
    slot_match = (frame == sirq_pkg::SLOT_TABLE[idx*6 +: 6]);
  endfunction

  // only the mapped frames can ever report a request
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign hit[i] = irq_i[i] && slot_match(slot.frame, i); // R15
  end

  assign slot.req = |hit;

endmodule // sirq_slot_map

//--- testbench/sirq_host_model.sv
// host side model of the shared serial interrupt line
`timescale 1ns/100ps
module sirq_host_model (
  input  wire logic mclk_i,
  input  wire logic line_i,
  output logic      host_oe_o,
  output logic      host_o
);
  initial begin
    host_oe_o = 1'b0;
    host_o    = 1'b1;
  end

  // ************************************************************
  // one clock: drive just after the edge, sample the line 6 ns after the edge
  // ************************************************************
  task automatic step(input logic oe, input logic lvl, output logic seen);
    @(posedge mclk_i);
    #1;
    host_oe_o = oe;
    host_o    = lvl;
    #5;
    seen = line_i;
  endtask

  // one full cycle: start, nframes frames, stop, one released clock
  task automatic run_cycle(input int start_len, input int stop_len, input int nframes,
                           output logic [32:1] low_seen, output logic dev_start);
    logic v;
    int   k;
    dev_start = 1'b0;
    low_seen  = '0;
    // idle clocks in which the device may open the cycle itself
    for (k = 0; k < 8 && dev_start !== 1'b1; k++) begin
      step(1'b0, 1'b1, v);
      dev_start = ~v;
    end
    // host takes over or starts alone, total low 4 to 8 clocks
    for (k = (dev_start === 1'b1) ? 1 : 0; k < start_len; k++) begin
      step(1'b1, 1'b0, v);
    end
    step(1'b1, 1'b1, v);
    // released from clock 1; frame n sampled in clock 3n-1; stop follows the last turnaround
    for (k = 1; k <= 3 * nframes + 1; k++) begin
      step(1'b0, 1'b1, v);
      if (k % 3 == 2) begin
        low_seen[(k + 1) / 3] = ~v;
      end
    end
    for (k = 0; k < stop_len; k++) begin
      step(1'b1, 1'b0, v);
    end
    step(1'b0, 1'b1, v);
  endtask
endmodule // sirq_host_model

//--- testbench/serial_irq_slave_tb.sv
// self-checking bench for the serialized interrupt slave
`timescale 1ns/100ps
module serial_irq_slave_tb;
  logic       mclk_i;
  logic       rst_i;
  logic [4:0] irq;
  logic       serirq_o;
  logic       serirq_oe_o;
  logic       quiet_mode_o;
  logic       host_oe;
  logic       host_o;
  wire logic  serirq_line;
  int         miscompares = 0;
  int         checked     = 0;
  int         cycles      = 0;
  int         seed        = 11;

  // wired line with pull-up: low when any enabled driver drives 0
  assign serirq_line = ~((serirq_oe_o & ~serirq_o) | (host_oe & ~host_o));

  sirq_slave sirq_slave_inst (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .serirq_i     (serirq_line),
    .irq_kbd_i    (irq[0]),
    .irq_smi_i    (irq[1]),
    .irq_ir_i     (irq[2]),
    .irq_uarta_i  (irq[3]),
    .irq_mouse_i  (irq[4]),
    .serirq_o     (serirq_o),
    .serirq_oe_o  (serirq_oe_o),
    .quiet_mode_o (quiet_mode_o)
  );

  sirq_host_model sirq_host_model_inst (
    .mclk_i    (mclk_i),
    .line_i    (serirq_line),
    .host_oe_o (host_oe),
    .host_o    (host_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // ************************************************************
  // comparison, reference model and verdict
  // ************************************************************
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [32:1] expect_lows(input int src, input int nf);
    int slot [5] = '{2, 3, 4, 5, 13};
    expect_lows = '0;
    for (int i = 0; i < 5; i++) begin
      if (src[i] && slot[i] <= nf) begin
        expect_lows[slot[i]] = 1'b1;
      end
    end
  endfunction

  task automatic close_out();
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      close_out();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [32:1] lows;
    logic        dstart;
    logic        quiet;
    int          src;
    int          start_len;
    int          stop_len;
    int          nframes;
    rst_i = 1'b1;
    irq   = 5'h00;
    quiet = 1'b0;
    repeat (8) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    for (int it = 0; it < 14; it++) begin
      @(posedge mclk_i);
      #1;
      // first cycle: all sources on in continuous mode; second: none in quiet
      src       = (it == 0) ? 31 : (it == 1) ? 0 : ($random(seed) & 31);
      irq       = src[4:0];
      start_len = 4 + (($random(seed) & 7) % 5);
      stop_len  = (it < 2) ? 2 : 2 + ($random(seed) & 1);
      // a host may end the cycle early, right after frame 17
      nframes   = (it < 2 || ($random(seed) & 1)) ? 32 : 17;
      check("quiet_mode_o", quiet_mode_o, quiet);
      sirq_host_model_inst.run_cycle(start_len, stop_len, nframes, lows, dstart);
      check("frame lows", lows, expect_lows(src, nframes));
      check("device start", dstart, quiet && src != 0);
      quiet = (stop_len == 2);
    end
    @(posedge mclk_i);
    #1;
    check("quiet_mode_o", quiet_mode_o, quiet);
    close_out();
  end
endmodule // serial_irq_slave_tb
